// File: cll_pkg.sv
// Package: register map, field layout and states of the loopback test engine
package cll_pkg;
    // --------------------------------------------------------------
    // Register byte addresses
    // --------------------------------------------------------------
    localparam logic [15:0] SRC_BASE_ADDR = 16'h0120;
    localparam logic [15:0] DST_BASE_ADDR = 16'h0128;
    localparam logic [15:0] LINE_CNT_ADDR = 16'h0130;
    localparam logic [15:0] CTRL_ADDR     = 16'h0138;
    localparam logic [15:0] CFG_ADDR      = 16'h0140;

    // --------------------------------------------------------------
    // Control word fields
    // --------------------------------------------------------------
    localparam int CTL_RUN_N_BIT = 0;
    localparam int CTL_START_BIT = 1;
    localparam int CTL_FORCE_BIT = 2;
    localparam int CTL_WIDTH     = 3;

    // --------------------------------------------------------------
    // Settings word fields
    // --------------------------------------------------------------
    localparam int CFG_IRQ_END_BIT = 29;
    localparam int CFG_IRQ_ERR_BIT = 28;
    localparam int CFG_PMS_HI      = 27;
    localparam int CFG_PMS_LO      = 20;
    localparam int CFG_VC_HI       = 13;
    localparam int CFG_VC_LO       = 12;
    localparam int CFG_RDK_HI      = 10;
    localparam int CFG_RDK_LO      = 9;
    localparam int CFG_GAP_BIT     = 8;
    localparam int CFG_BURST_HI    = 6;
    localparam int CFG_BURST_LO    = 5;
    localparam int CFG_MODE_HI     = 4;
    localparam int CFG_MODE_LO     = 2;
    localparam int CFG_CONT_BIT    = 1;
    localparam int CFG_WT_BIT      = 0;
    localparam logic [31:0] CFG_USED_MASK = 32'h3ff0_377f;

    // --------------------------------------------------------------
    // Encodings and reset values
    // --------------------------------------------------------------
    localparam logic [2:0]  MODE_COPY    = 3'h0;
    localparam logic [2:0]  MODE_READ    = 3'h1;
    localparam logic [2:0]  MODE_WRITE   = 3'h2;
    localparam logic [2:0]  MODE_THROUGHPUT_MODE   = 3'h3;
    localparam logic [1:0]  RDK_SHARED   = 2'h0;
    localparam logic [1:0]  RDK_INVAL    = 2'h1;
    localparam logic [1:0]  RDK_MIXED    = 2'h3;
    localparam logic [1:0]  BURST_BAD    = 2'h2;
    localparam logic [63:0] BASE_RST     = 64'h0;
    localparam logic [31:0] WORD_RST     = 32'h0;
    localparam logic [15:0] LFSR_SEED    = 16'hace1;
    localparam int          LINE_BITS    = 14;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STATUS, ST_DONE} cll_state_e;
endpackage : cll_pkg

// File: cll_ctrl.sv
// Control registers and request engine of the cache-line loopback test
// --------------------------------------------------------------
// --------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module cll_ctrl #(
    parameter int N = cll_pkg::LINE_BITS
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register write port
    input  wire logic        csr_wr_en,
    input  wire logic [15:0] csr_wr_addr,
    input  wire logic [63:0] csr_wr_data,
    // Register read port
    input  wire logic        csr_rd_en,
    input  wire logic [15:0] csr_rd_addr,
    output logic             csr_rd_valid,
    output logic      [63:0] csr_rd_data,
    // Memory requests
    output logic             req_valid,
    input  wire logic        req_ready,
    output logic             req_write,
    output logic      [63:0] req_addr,
    output logic       [1:0] req_vc,
    output logic             req_rd_inval,
    output logic             req_wr_through,
    output logic       [1:0] req_burst,
    input  wire logic        rsp_valid,
    input  wire logic        err_in,
    // Status record write
    output logic             status_valid,
    input  wire logic        status_ready,
    output logic             status_error,
    output logic      [31:0] status_reads,
    output logic      [31:0] status_writes,
    output logic      [63:0] status_clocks,
    // Misc
    output logic       [7:0] per_mode_settings,
    output logic             irq_pulse,
    output logic             test_busy
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic [63:0] src_r, src_nxt, dst_r, dst_nxt, clk_cnt_r, clk_cnt_nxt;
    logic [31:0] lines_r, lines_nxt, cfg_r, cfg_nxt, nrd_r, nrd_nxt, nwr_r, nwr_nxt;
    logic [2:0]  ctl_r, ctl_nxt;
    logic [N-1:0] line_r, line_nxt;
    logic [15:0] lfsr_r, lfsr_nxt;
    logic [3:0]  gap_r, gap_nxt;
    logic        wr_phase_r, wr_phase_nxt, wait_rsp_r, wait_rsp_nxt, err_r, err_nxt;
    logic        rdv_r, rdv_nxt, irq_r, irq_nxt, busy_r, busy_nxt;
    logic [63:0] rdd_r, rdd_nxt;
    typedef cll_pkg::cll_state_e cll_state_e_t;
    cll_state_e_t state_r, state_nxt;
    // Request and status outputs held in flops
    logic        rv_r, rv_nxt, rw_r, rw_nxt, ri_r, ri_nxt, sv_r, sv_nxt, wt_r, wt_nxt;
    logic [63:0] ra_r, ra_nxt;
    logic [1:0]  rb_r, rb_nxt, vc_r, vc_nxt;

    function automatic logic [15:0] cll_lfsr(input logic [15:0] v);
        cll_lfsr = {1'b0, v[15:1]} ^ (v[0] ? 16'hb400 : 16'h0000);
    endfunction : cll_lfsr

    function automatic logic [63:0] cll_align(input logic [63:0] v);
        cll_align = v & ~((64'h1 << N) - 64'h1);
    endfunction : cll_align

    // --------------------------------------------------------------
    // Decoded fields
    // --------------------------------------------------------------
    logic [2:0] mode;
    logic [1:0] rdk, burst;
    logic       wr_hit, ctl_wr, start_p, force_p, accept, issue_ok, do_write;
    logic [N:0] line_step;

    always_comb begin
        mode     = cfg_r[cll_pkg::CFG_MODE_HI:cll_pkg::CFG_MODE_LO];
        rdk      = cfg_r[cll_pkg::CFG_RDK_HI:cll_pkg::CFG_RDK_LO];
        burst    = cfg_r[cll_pkg::CFG_BURST_HI:cll_pkg::CFG_BURST_LO];
        wr_hit   = csr_wr_en && ctl_r[cll_pkg::CTL_RUN_N_BIT];
        ctl_wr   = csr_wr_en && csr_wr_addr == cll_pkg::CTRL_ADDR;
        // start on a write of 3 once out of reset
        start_p  = ctl_wr && ctl_r[cll_pkg::CTL_RUN_N_BIT]
                   && csr_wr_data[cll_pkg::CTL_RUN_N_BIT]
                   && csr_wr_data[cll_pkg::CTL_START_BIT]
                   && (state_r == cll_pkg::ST_IDLE || state_r == cll_pkg::ST_DONE);
        force_p  = ctl_wr && csr_wr_data[cll_pkg::CTL_RUN_N_BIT]
                   && csr_wr_data[cll_pkg::CTL_FORCE_BIT] && state_r == cll_pkg::ST_RUN;
        accept   = rv_r && req_ready;
        // No new request once the run is ending, so nothing goes unreported
        issue_ok = state_r == cll_pkg::ST_RUN && !rv_r && gap_r == 4'h0 && !wait_rsp_r
                   && lines_r != 32'h0 && !force_p && !err_in;
        // pattern decides read or write per step
        do_write = mode == cll_pkg::MODE_WRITE
                   || ((mode == cll_pkg::MODE_COPY || mode == cll_pkg::MODE_THROUGHPUT_MODE)
                       && wr_phase_r);
        line_step = {1'b0, line_r} + {{(N - 1){1'b0}}, burst} + {{N{1'b0}}, 1'b1};
    end

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    always_comb begin
        src_nxt = src_r;  dst_nxt = dst_r;  lines_nxt = lines_r;  cfg_nxt = cfg_r;
        ctl_nxt = ctl_r;  state_nxt = state_r;  line_nxt = line_r;
        lfsr_nxt = cll_lfsr(lfsr_r);  gap_nxt = gap_r;  err_nxt = err_r;
        wr_phase_nxt = wr_phase_r;  wait_rsp_nxt = wait_rsp_r && !rsp_valid;
        // Accepts counted in any state, so a request drained at the end is reported
        nrd_nxt = nrd_r + {31'h0, accept && !rw_r};  nwr_nxt = nwr_r + {31'h0, accept && rw_r};
        clk_cnt_nxt = clk_cnt_r;
        rv_nxt = rv_r && !req_ready;  rw_nxt = rw_r;  ra_nxt = ra_r;  ri_nxt = ri_r;
        rb_nxt = rb_r;  vc_nxt = vc_r;  sv_nxt = sv_r && !status_ready;  wt_nxt = wt_r;
        irq_nxt = 1'b0;
        rdv_nxt = csr_rd_en;
        rdd_nxt = 64'h0;
        // unmapped addresses and unused bits read zero
        if (csr_rd_en) begin
            case (csr_rd_addr)
                cll_pkg::SRC_BASE_ADDR: rdd_nxt = src_r;
                cll_pkg::DST_BASE_ADDR: rdd_nxt = dst_r;
                cll_pkg::LINE_CNT_ADDR: rdd_nxt = {32'h0, lines_r};
                cll_pkg::CTRL_ADDR:     rdd_nxt = {61'h0, ctl_r};
                cll_pkg::CFG_ADDR:      rdd_nxt = {32'h0, cfg_r};
                default:                rdd_nxt = 64'h0;
            endcase
        end
        if (ctl_wr) begin
            ctl_nxt = csr_wr_data[cll_pkg::CTL_WIDTH-1:0];
        end
        if (wr_hit) begin
            case (csr_wr_addr)
                cll_pkg::SRC_BASE_ADDR: src_nxt = cll_align(csr_wr_data);
                cll_pkg::DST_BASE_ADDR: dst_nxt = cll_align(csr_wr_data);
                // only the low N count bits are stored
                cll_pkg::LINE_CNT_ADDR: lines_nxt = {{(32 - N){1'b0}}, csr_wr_data[N-1:0]};
                cll_pkg::CFG_ADDR: begin
                    cfg_nxt = csr_wr_data[31:0] & cll_pkg::CFG_USED_MASK;
                    // reserved burst length keeps old value
                    if (csr_wr_data[cll_pkg::CFG_BURST_HI:cll_pkg::CFG_BURST_LO]
                        == cll_pkg::BURST_BAD) begin
                        cfg_nxt[cll_pkg::CFG_BURST_HI:cll_pkg::CFG_BURST_LO] = burst;
                    end
                end
                default: ;
            endcase
        end
        case (state_r)
            cll_pkg::ST_IDLE, cll_pkg::ST_DONE: begin
                if (start_p) begin
                    state_nxt = cll_pkg::ST_RUN;
                    line_nxt = '0;  nrd_nxt = 32'h0;  nwr_nxt = 32'h0;
                    clk_cnt_nxt = 64'h0;  err_nxt = 1'b0;  gap_nxt = 4'h0;
                    wr_phase_nxt = 1'b0;  wait_rsp_nxt = 1'b0;
                end
            end
            cll_pkg::ST_RUN: begin
                clk_cnt_nxt = clk_cnt_r + 64'h1;
                if (gap_r != 4'h0) begin
                    gap_nxt = gap_r - 4'h1;
                end
                if (issue_ok) begin
                    rv_nxt = 1'b1;
                    rw_nxt = do_write;
                    ra_nxt = (do_write ? dst_r : src_r) + {{(64 - N){1'b0}}, line_r};
                    vc_nxt = cfg_r[cll_pkg::CFG_VC_HI:cll_pkg::CFG_VC_LO];
                    rb_nxt = burst;
                    ri_nxt = !do_write
                        && (rdk == cll_pkg::RDK_MIXED ? lfsr_r[0] : rdk == cll_pkg::RDK_INVAL);
                    wt_nxt = do_write && cfg_r[cll_pkg::CFG_WT_BIT];
                end
                if (accept) begin
                    gap_nxt = cfg_r[cll_pkg::CFG_GAP_BIT] ? lfsr_r[3:0] : 4'h0;
                    if ((mode == cll_pkg::MODE_COPY || mode == cll_pkg::MODE_THROUGHPUT_MODE)
                        && !rw_r) begin
                        wr_phase_nxt = 1'b1;
                        wait_rsp_nxt = mode == cll_pkg::MODE_COPY;
                    end else begin
                        wr_phase_nxt = 1'b0;
                        line_nxt = line_step[N-1:0];
                        // stop or wrap at the line count
                        if ({{(31 - N){1'b0}}, line_step} >= lines_r) begin
                            line_nxt = '0;
                            if (!cfg_r[cll_pkg::CFG_CONT_BIT]) begin
                                state_nxt = cll_pkg::ST_STATUS;
                            end
                        end
                    end
                end
                if (err_in) begin
                    err_nxt = 1'b1;
                    state_nxt = cll_pkg::ST_STATUS;
                    irq_nxt = cfg_r[cll_pkg::CFG_IRQ_ERR_BIT];
                end
                // forced completion takes the normal end path
                if (force_p) begin
                    state_nxt = cll_pkg::ST_STATUS;
                end
                if (lines_r == 32'h0) begin
                    state_nxt = cll_pkg::ST_STATUS;
                end
            end
            cll_pkg::ST_STATUS: begin
                // one shared end sequence, request channel drained
                if (!rv_r && !sv_r) begin
                    sv_nxt = 1'b1;
                end
                if (sv_r && status_ready) begin
                    state_nxt = cll_pkg::ST_DONE;
                    irq_nxt = cfg_r[cll_pkg::CFG_IRQ_END_BIT];
                end
            end
            default: state_nxt = cll_pkg::ST_IDLE;
        endcase
        if (!ctl_nxt[cll_pkg::CTL_RUN_N_BIT]) begin
            src_nxt = cll_pkg::BASE_RST;  dst_nxt = cll_pkg::BASE_RST;
            lines_nxt = cll_pkg::WORD_RST;  cfg_nxt = cll_pkg::WORD_RST;
            state_nxt = cll_pkg::ST_IDLE;  rv_nxt = 1'b0;  sv_nxt = 1'b0;
            irq_nxt = 1'b0;
        end
        busy_nxt = state_nxt == cll_pkg::ST_RUN;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            src_r <= cll_pkg::BASE_RST;  dst_r <= cll_pkg::BASE_RST;
            lines_r <= cll_pkg::WORD_RST;  cfg_r <= cll_pkg::WORD_RST;
            ctl_r <= 3'h0;  state_r <= cll_pkg::ST_IDLE;  line_r <= '0;
            lfsr_r <= cll_pkg::LFSR_SEED;  gap_r <= 4'h0;  err_r <= 1'b0;
            wr_phase_r <= 1'b0;  wait_rsp_r <= 1'b0;
            nrd_r <= 32'h0;  nwr_r <= 32'h0;  clk_cnt_r <= 64'h0;
            rv_r <= 1'b0;  rw_r <= 1'b0;  ra_r <= 64'h0;  ri_r <= 1'b0;
            rb_r <= 2'h0;  vc_r <= 2'h0;  sv_r <= 1'b0;  irq_r <= 1'b0;  wt_r <= 1'b0;
            rdv_r <= 1'b0;  rdd_r <= 64'h0;  busy_r <= 1'b0;
        end else begin
            src_r <= src_nxt;  dst_r <= dst_nxt;  lines_r <= lines_nxt;  cfg_r <= cfg_nxt;
            ctl_r <= ctl_nxt;  state_r <= state_nxt;  line_r <= line_nxt;
            lfsr_r <= lfsr_nxt;  gap_r <= gap_nxt;  err_r <= err_nxt;
            wr_phase_r <= wr_phase_nxt;  wait_rsp_r <= wait_rsp_nxt;
            nrd_r <= nrd_nxt;  nwr_r <= nwr_nxt;  clk_cnt_r <= clk_cnt_nxt;
            rv_r <= rv_nxt;  rw_r <= rw_nxt;  ra_r <= ra_nxt;  ri_r <= ri_nxt;
            rb_r <= rb_nxt;  vc_r <= vc_nxt;  sv_r <= sv_nxt;  irq_r <= irq_nxt;  wt_r <= wt_nxt;
            rdv_r <= rdv_nxt;  rdd_r <= rdd_nxt;  busy_r <= busy_nxt;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign csr_rd_valid   = rdv_r;
    assign csr_rd_data    = rdd_r;
    assign req_valid      = rv_r;
    assign req_write      = rw_r;
    assign req_addr       = ra_r;
    assign req_vc         = vc_r;
    assign req_rd_inval   = ri_r;
    assign req_wr_through = wt_r;
    assign req_burst      = rb_r;
    assign status_valid   = sv_r;
    assign status_error   = err_r;
    assign status_reads   = nrd_r;
    assign status_writes  = nwr_r;
    assign status_clocks  = clk_cnt_r;
    // per-mode field handed to the pattern logic
    assign per_mode_settings = cfg_r[cll_pkg::CFG_PMS_HI:cll_pkg::CFG_PMS_LO];
    assign irq_pulse      = irq_r;
    assign test_busy      = busy_r;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence force_seq;
        force_p && !rst && ctl_nxt[0] && !err_in;
    endsequence
    sequence end_seq;
        state_r == cll_pkg::ST_STATUS ##[1:300] status_valid;
    endsequence

    src_align_a: assert property (wr_hit && csr_wr_addr == cll_pkg::SRC_BASE_ADDR
        |=> src_r == cll_align($past(csr_wr_data))) else $error("source base wrong");
    dst_align_a: assert property (wr_hit && csr_wr_addr == cll_pkg::DST_BASE_ADDR
        |=> dst_r[N-1:0] == '0) else $error("dest base unaligned");
    line_high_a: assert property (lines_r[31:N] == '0) else $error("count high bits set");
    force_end_a: assert property (force_seq |=> end_seq) else $error("force lost");
    end_state_a: assert property (status_valid && status_ready |=> state_r == cll_pkg::ST_DONE
        && !req_valid ##1 !status_valid) else $error("end state differs");
    test_rst_a: assert property (!ctl_r[0] |-> cfg_r == 32'h0 && lines_r == 32'h0)
        else $error("test reset kept settings");
    end_irq_a: assert property (status_valid && status_ready && cfg_r[29] && ctl_r[0]
        |=> irq_pulse) else $error("no end interrupt");
    err_irq_a: assert property (test_busy && err_in && cfg_r[28] && ctl_nxt[0]
        |=> irq_pulse) else $error("no error interrupt");
    burst_ok_a: assert property (cfg_r[6:5] != cll_pkg::BURST_BAD)
        else $error("bad burst length");
    read_only_a: assert property (req_valid && cfg_r[4:2] == cll_pkg::MODE_READ
        && $stable(cfg_r) && $past(test_busy) |-> !req_write)
        else $error("write in read mode");
    wrap_a: assert property (test_busy && cfg_r[1] && !err_in && !force_p && lines_r != 32'h0
        && ctl_nxt[0] |=> test_busy) else $error("wrap mode stopped");
    ctl_read_a: assert property (csr_rd_en && csr_rd_addr == cll_pkg::CTRL_ADDR
        |=> csr_rd_data[63:3] == '0) else $error("control high bits set");
endmodule : cll_ctrl
`default_nettype wire

// File: cll_mem_model.sv
// Memory side model: random ready, delayed read responses
`timescale 1ns/1ps
`default_nettype none
module cll_mem_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // From the engine
    input  wire logic req_valid,
    input  wire logic req_write,
    input  wire logic status_valid,
    // To the engine
    output var logic  req_ready = 1'b0,
    output var logic  rsp_valid = 1'b0,
    output var logic  status_ready = 1'b0
);
    int pend = 0;
    // Ready drops at random, so held requests are exercised
    always @(posedge clock) begin
        if (rst) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            status_ready <= 1'b0;
            pend = 0;
        end else begin
            if (req_valid && req_ready && !req_write) pend++;
            req_ready <= 1'($urandom_range(1, 0));
            status_ready <= 1'($urandom_range(1, 0));
            rsp_valid <= 1'b0;
            if (pend > 0 && $urandom_range(3, 0) == 0) begin
                rsp_valid <= 1'b1;
                pend--;
            end
        end
    end
endmodule : cll_mem_model
`default_nettype wire

// File: tb_cll_ctrl.sv
// Self-checking testbench of the loopback test engine control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_cll_ctrl;
    localparam int N = cll_pkg::LINE_BITS;
    logic        clock = 1'b0, rst = 1'b1, csr_wr_en = 1'b0, csr_rd_en = 1'b0, err_in = 1'b0;
    logic [15:0] csr_wr_addr = 16'h0, csr_rd_addr = 16'h0;
    logic [63:0] csr_wr_data = 64'h0, csr_rd_data, req_addr, src, dst, status_clocks;
    logic [63:0] busy_cyc = 64'h0;
    logic        csr_rd_valid, req_valid, req_ready, req_write, req_rd_inval, req_wr_through;
    logic        rsp_valid, status_valid, status_ready, status_error, irq_pulse, test_busy;
    logic [1:0]  req_vc, req_burst;
    logic [7:0]  per_mode_settings;
    logic [31:0] status_reads, status_writes, cfg, cnt, nrd, nwr, ri, wi;
    int          err_total = 0, num_checks = 0, cyc = 0;

    cll_ctrl uut (.clock, .rst, .csr_wr_en, .csr_wr_addr, .csr_wr_data, .csr_rd_en,
        .csr_rd_addr, .csr_rd_valid, .csr_rd_data, .req_valid, .req_ready, .req_write,
        .req_addr, .req_vc, .req_rd_inval, .req_wr_through, .req_burst, .rsp_valid, .err_in,
        .status_valid, .status_ready, .status_error, .status_reads, .status_writes,
        .status_clocks, .per_mode_settings, .irq_pulse, .test_busy);
    cll_mem_model mem (.clock, .rst, .req_valid, .req_write, .status_valid, .req_ready,
        .rsp_valid, .status_ready);

    initial forever #2.5 clock = ~clock;

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    // Next line index, wrapping at the count
    function automatic logic [31:0] nxt(input logic [31:0] i);
        nxt = (i + cfg[6:5] + 1 >= cnt) ? 32'h0 : i + cfg[6:5] + 1;
    endfunction : nxt

    // Cycles spent running, for the clock counter of the record
    always @(posedge clock) if (test_busy) busy_cyc++;

    // ------------------------------------------------------------
    // Request monitor
    // ------------------------------------------------------------
    always @(posedge clock) if (req_valid && req_ready) begin
        `CHK({req_vc, req_burst}, {cfg[13:12], cfg[6:5]})
        `CHK(per_mode_settings, cfg[27:20])
        if (req_write) begin
            `CHK({req_addr, req_wr_through}, {dst + wi, cfg[0]})
            nwr++;
            wi = nxt(wi);
        end else begin
            `CHK(req_addr, src + ri)
            if (cfg[10:9] != 2'h3) `CHK(req_rd_inval, cfg[9])
            nrd++;
            ri = nxt(ri);
        end
    end

    // ------------------------------------------------------------
    // Register and test tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [63:0] d);
        csr_wr_en <= 1'b1;
        csr_wr_addr <= a;
        csr_wr_data <= d;
        @(posedge clock);
        csr_wr_en <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [63:0] e);
        csr_rd_en <= 1'b1;
        csr_rd_addr <= a;
        @(posedge clock);
        csr_rd_en <= 1'b0;
        #1;
        `CHK({csr_rd_valid, csr_rd_data}, {1'b1, e})
        @(posedge clock);
    endtask : rd

    task automatic run(input logic [31:0] c, input logic [31:0] n);
        cfg = c & cll_pkg::CFG_USED_MASK;
        cnt = n;
        src = {$urandom(), $urandom()} & ({64{1'b1}} << N);
        dst = {$urandom(), $urandom()} & ({64{1'b1}} << N);
        ri = 0;
        wi = 0;
        nrd = 0;
        nwr = 0;
        busy_cyc = 64'h0;
        wr(cll_pkg::CTRL_ADDR, 64'h1);
        wr(cll_pkg::SRC_BASE_ADDR, src);
        wr(cll_pkg::DST_BASE_ADDR, dst);
        wr(cll_pkg::LINE_CNT_ADDR, 64'(n));
        wr(cll_pkg::CFG_ADDR, 64'(c));
        wr(cll_pkg::CTRL_ADDR, 64'h3);
    endtask : run

    // Waits for the status record; an all-ones read count means the counts are not known ahead
    task automatic fin(input string nm, input logic [31:0] er, ew, input logic ee);
        int k;
        k = 0;
        // Looked at on the edge itself: the record may be taken at the very first one
        do begin
            @(posedge clock);
            k++;
        end while (!(status_valid && status_ready) && k < 3000);
        `CHK(k < 3000, 1'b1)
        if (er != '1) `CHK({status_reads, status_writes}, {er, ew})
        `CHK({status_error, status_reads, status_writes}, {ee, nrd, nwr})
        `CHK(status_clocks, busy_cyc)
        #1;
        `CHK({irq_pulse, test_busy}, {cfg[29], 1'b0})
        @(posedge clock);
        $display("test %s done", nm);
    endtask : fin

    initial begin
        void'($urandom(32'h0a67));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 6; i++) rd(16'h0120 + 16'(8 * i), 64'h0);
        wr(cll_pkg::CTRL_ADDR, 64'h1);
        wr(cll_pkg::LINE_CNT_ADDR, '1);
        rd(cll_pkg::LINE_CNT_ADDR, 64'((1 << N) - 1));
        wr(cll_pkg::CFG_ADDR, 64'hffff_ffff);
        rd(cll_pkg::CFG_ADDR, 64'(cll_pkg::CFG_USED_MASK));
        wr(cll_pkg::CFG_ADDR, 64'h0000_0040);
        // Reserved burst value 2 leaves the earlier 3 in place
        rd(cll_pkg::CFG_ADDR, 64'h0000_0060);
        wr(cll_pkg::CTRL_ADDR, 64'h0);
        wr(cll_pkg::CFG_ADDR, 64'hffff_ffff);
        wr(cll_pkg::CTRL_ADDR, 64'h1);
        rd(cll_pkg::CFG_ADDR, 64'h0);
        $display("test registers done");
        // Every pattern with every legal burst, count 0 as a corner
        for (int m = 0; m < 4; m++) for (int b = 0; b < 3; b++) begin
            logic [31:0] n, c, q, rk, k;
            n = (m == 0 && b == 0) ? 32'h0 : 32'($urandom_range(9, 1));
            q = (b == 2) ? 32'h3 : 32'(b);
            rk = 32'($urandom_range(2, 0));
            if (rk == 2) rk = 3;
            c = ($urandom() & 32'h2ff0_3101) | (rk << 9) | (q << 5) | (32'(m) << 2);
            k = (n + q) / (q + 1);
            run(c, n);
            fin("pattern", (m == 2) ? 32'h0 : k, (m == 1) ? 32'h0 : k, 1'b0);
        end
        // Wrapping read run ended by force
        run(32'h0000_0006, 3);
        for (int k = 0; k < 300 && nrd < 5; k++) @(posedge clock);
        `CHK(nrd >= 5, 1'b1)
        wr(cll_pkg::CTRL_ADDR, 64'h5);
        fin("force", '1, 0, 1'b0);
        // Wrapping write run ended by an error
        run(32'h1000_000a, 4);
        repeat (20) @(posedge clock);
        err_in <= 1'b1;
        @(posedge clock);
        err_in <= 1'b0;
        #1;
        `CHK(irq_pulse, 1'b1)
        @(posedge clock);
        fin("error", '1, 0, 1'b1);
        wrap_up();
    end
endmodule : tb_cll_ctrl
`default_nettype wire
